// ==== core/sdbpim_top.sv ====
// top: pin sync, command decode, clock enable machine, read data timing
// assumes controller pins asynchronous to mclk, hence two flops each
`timescale 1ns/1ps
module sdbpim_top (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// command pins
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic        cke,
	input  wire logic [1:0]  bank,
	input  wire logic [12:0] addr,
	// status
	output logic [4:0]       power_state,
	output logic             all_idle,
	output logic             read_valid,
	output logic             write_taken,
	output logic [12:0]      mode_word
);
	import sdbpim_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	sdbpim_cmd_type s1_ff, s2_ff, prev_ff;  // two stages + last cmd
	sdbpim_cmd_type raw;                     // raw pin bundle

	assign raw = '{code: {cs_n, ras_n, cas_n, we_n}, bank: bank,
		addr: addr, cke: cke};

	always_ff @(posedge mclk) begin
		if (srst) begin
			s1_ff   <= '{code: CMD_NOP, bank: 2'h0, addr: 13'h0, cke: 1'b0};
			s2_ff   <= '{code: CMD_NOP, bank: 2'h0, addr: 13'h0, cke: 1'b0};
			prev_ff <= '{code: CMD_NOP, bank: 2'h0, addr: 13'h0, cke: 1'b0};
		end else begin
			s1_ff   <= raw;
			s2_ff   <= s1_ff;
			prev_ff <= s2_ff;
		end
	end

	// ****************************************
	// command decode
	// ****************************************
	sdbpim_cmd_type cmd;         // command at this edge
	logic           inhibit;     // chip select high
	logic           nop_like;    // inhibit or nop
	logic           cke_prev;    // clock enable at last edge
	logic           go;          // command takes effect

	assign cmd      = s2_ff;
	assign cke_prev = prev_ff.cke;
	assign inhibit  = cmd.code[3];
	assign nop_like = inhibit || cmd.code == CMD_NOP;

	// ****************************************
	// banks and mode register
	// ****************************************
	logic [3:0] bk_burst;     // per bank bursting
	logic [3:0] bk_idle;      // per bank idle
	logic [3:0] burst_len;    // programmed length
	logic [1:0] read_lat;     // programmed latency
	logic       single_wr;    // write burst mode
	logic       any_burst;    // some bank bursting

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_bank
			sdbpim_bank sdbpim_bank_i (
				.mclk      (mclk),
				.srst      (srst),
				.go        (go),
				.cmd       (cmd),
				.mine      (cmd.bank == 2'(gi)),
				.burst_len (burst_len),
				.single_wr (single_wr),
				.bursting  (bk_burst[gi]),
				.is_idle   (bk_idle[gi])
			);
		end
	endgenerate

	assign any_burst = |bk_burst;
	assign all_idle  = &bk_idle;

	sdbpim_mode sdbpim_mode_i (
		.mclk      (mclk),
		.srst      (srst),
		.go        (go),
		.cmd       (cmd),
		.all_idle  (all_idle),
		.burst_len (burst_len),
		.burst_seq (),
		.read_lat  (read_lat),
		.single_wr (single_wr),
		.mode_q    (mode_word)
	);

	// ****************************************
	// clock enable state machine
	// ****************************************
	sdbpim_pwr_type pw_ff, nxt_pw;   // power state

	always_comb begin
		nxt_pw = pw_ff;
		unique case (pw_ff)
			PW_RUN: begin
				// high-to-low edge picks the low-power state
				if (cke_prev && !cmd.cke && !inhibit) begin
					if (any_burst)
						nxt_pw = PW_SUSP;
					else if (all_idle && cmd.code == CMD_TERM)
						nxt_pw = PW_DPD;
					else if (all_idle && cmd.code == CMD_REFRESH)
						nxt_pw = PW_SR;
					// nop, or any other command while idle
					else if (all_idle)
						nxt_pw = PW_PD;
				end else if (cke_prev && !cmd.cke && all_idle) begin
					nxt_pw = PW_PD;
				end
			end
			PW_PD: begin
				if (cmd.cke && nop_like)
					nxt_pw = PW_RUN;
			end
			PW_SR: begin
				// controller then keeps nops for the exit time
				if (cmd.cke && nop_like)
					nxt_pw = PW_RUN;
			end
			PW_SUSP: begin
				if (cmd.cke)
					nxt_pw = PW_RUN;
			end
			PW_DPD: begin
				if (cmd.cke)
					nxt_pw = PW_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst)
			pw_ff <= PW_RUN;
		else
			pw_ff <= nxt_pw;
	end

	// commands act only with clock enable high at both edges
	assign go = (pw_ff == PW_RUN) && cke_prev && cmd.cke && !inhibit;
	assign power_state = pw_ff;

	// ****************************************
	// read data timing
	// ****************************************
	logic [2:0] lat_ff, nxt_lat;   // read issue pipeline
	logic       wr_ff, nxt_wr;     // write word taken
	logic       rd_now;            // read registered now

	assign rd_now = go && cmd.code == CMD_READ;

	// suspend freezes the pipe; a new read shifts in at bit zero
	always_comb begin
		nxt_lat = lat_ff;
		nxt_wr  = 1'b0;
		if (pw_ff != PW_SUSP) begin
			nxt_lat = {lat_ff[1:0], rd_now};
			nxt_wr  = go && cmd.code == CMD_WRITE;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			lat_ff <= 3'h0;
			wr_ff  <= 1'b0;
		end else begin
			lat_ff <= nxt_lat;
			wr_ff  <= nxt_wr;
		end
	end

	// data becomes valid read_lat edges after the read
	assign read_valid  = (read_lat == 2'h3) ? lat_ff[2] : lat_ff[1];
	assign write_taken = wr_ff;

	// ****************************************
	// checks
	// ****************************************
	a_pd_exit: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff == PW_PD && cmd.cke && nop_like)
		|=> pw_ff == PW_RUN)
		else $error("power-down exit late");
	a_dpd_entry: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff == PW_RUN && cke_prev && !cmd.cke && all_idle
		 && cmd.code == CMD_TERM) |=> pw_ff == PW_DPD)
		else $error("deep power-down not entered");
	a_sr_entry: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff == PW_RUN && cke_prev && !cmd.cke && all_idle
		 && cmd.code == CMD_REFRESH) |=> pw_ff == PW_SR)
		else $error("self refresh not entered");
	a_susp_exit: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff == PW_SUSP && cmd.cke) |=> pw_ff == PW_RUN)
		else $error("suspend exit late");
	a_lat_two: assert property (@(posedge mclk) disable iff (srst)
		(rd_now && read_lat == 2'h2 && pw_ff == PW_RUN)
		##1 (pw_ff != PW_SUSP) |=> read_valid)
		else $error("read data not at latency two");
	c_dpd: cover property (@(posedge mclk) pw_ff == PW_DPD);
	c_susp: cover property (@(posedge mclk) pw_ff == PW_SUSP);

	// ****************************************
	// mode, pipeline and clock enable checks
	// ****************************************
	// a load with an open bank must leave the stored word alone
	a_load_refused: assert property (@(posedge mclk) disable iff (srst)
		(go && cmd.code == CMD_LOAD && !all_idle)
		|=> $stable(mode_word))
		else $error("mode loaded with a bank open");
	// three-clock latency: two unsuspended shifts after the read
	a_lat_three: assert property (@(posedge mclk) disable iff (srst)
		(rd_now && read_lat == 2'h3 && pw_ff == PW_RUN)
		##1 (pw_ff != PW_SUSP) ##1 (pw_ff != PW_SUSP)
		|=> read_valid)
		else $error("read data not at latency three");
	// write word pulse follows every accepted write
	a_write_pulse: assert property (@(posedge mclk) disable iff (srst)
		(go && cmd.code == CMD_WRITE) |=> write_taken)
		else $error("write word not taken");
	// idle banks with a falling clock enable and a nop power down
	a_pd_entry: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff == PW_RUN && cke_prev && !cmd.cke && all_idle
		 && nop_like) |=> pw_ff == PW_PD)
		else $error("power-down not entered");
	// a falling clock enable in mid burst enters suspend, freezing the read pipe
	a_susp_entry: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff == PW_RUN && cke_prev && !cmd.cke && !inhibit
		 && any_burst) |=> pw_ff == PW_SUSP)
		else $error("clock suspend not entered");
	// low-power states hold while clock enable stays low
	a_low_hold: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff != PW_RUN && !cmd.cke) |=> $stable(pw_ff))
		else $error("low-power state left with clock enable low");
	// the read pipe must not advance while suspended
	a_susp_freeze: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff == PW_SUSP) |=> $stable(lat_ff))
		else $error("read pipe moved in clock suspend");
	// power-down exit leaves every bank idle for the next edge
	a_pd_idle: assert property (@(posedge mclk) disable iff (srst)
		(pw_ff == PW_PD && cmd.cke && nop_like) |=> all_idle)
		else $error("banks not idle after power-down exit");

endmodule // sdbpim_top

// ==== core/sdbpim_pkg.sv ====
// package for the sdram bank, power and mode command core
// assumes one 200 MHz clock and a controller driving commands on pins
package sdbpim_pkg;

	// ****************************************
	// command encodings {cs,ras,cas,we}
	// ****************************************
	localparam logic [3:0] CMD_NOP     = 4'h7;
	localparam logic [3:0] CMD_ACTIVE  = 4'h3;
	localparam logic [3:0] CMD_READ    = 4'h5;
	localparam logic [3:0] CMD_WRITE   = 4'h4;
	localparam logic [3:0] CMD_PRE     = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_LOAD    = 4'h0;
	localparam logic [3:0] CMD_TERM    = 4'h6;

	// ****************************************
	// mode register fields
	// ****************************************
	localparam int          MODE_W         = 13;
	localparam int          BL_LSB         = 0;
	localparam int          BTYPE_POS      = 3;
	localparam int          LAT_LSB        = 4;
	localparam int          WBM_POS        = 9;
	localparam logic [12:0] MODE_RESET     = 13'h0022;
	localparam int          AP_POS         = 10;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ       = 200;
	localparam int TWR_NS        = 15;
	localparam int TRP_NS        = 18;
	localparam int WR_CYC  = (TWR_NS * CLK_MHZ + 999) / 1000;
	localparam int RP_CYC  = (TRP_NS * CLK_MHZ + 999) / 1000;

	// decoded command from the pins
	typedef struct packed {
		logic [3:0]  code;   // cs ras cas we
		logic [1:0]  bank;   // bank select
		logic [12:0] addr;   // address
		logic        cke;    // clock enable level
	} sdbpim_cmd_type;

	// bank states
	typedef enum logic [5:0] {
		BK_IDLE = 6'h01,
		BK_ACT  = 6'h02,
		BK_RD   = 6'h04,
		BK_WR   = 6'h08,
		BK_WREC = 6'h10,
		BK_PRE  = 6'h20
	} sdbpim_bank_type;

	// clock enable states
	typedef enum logic [4:0] {
		PW_RUN  = 5'h01,
		PW_PD   = 5'h02,
		PW_SR   = 5'h04,
		PW_SUSP = 5'h08,
		PW_DPD  = 5'h10
	} sdbpim_pwr_type;

endpackage

// ==== core/sdbpim_bank.sv ====
// one bank: burst, auto precharge, recovery and precharge timing
// assumes decoded, synchronised command from the top
`timescale 1ns/1ps
module sdbpim_bank (
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    srst,
	// command from top
	input  wire logic                    go,
	input  wire sdbpim_pkg::sdbpim_cmd_type cmd,
	input  wire logic                    mine,
	input  wire logic [3:0]              burst_len,
	input  wire logic                    single_wr,
	// state out
	output logic                         bursting,
	output logic                         is_idle
);
	import sdbpim_pkg::*;

	// ****************************************
	// state
	// ****************************************
	sdbpim_bank_type st_ff, nxt_st;       // bank state
	logic [3:0]      cnt_ff, nxt_cnt;     // burst / timing count
	logic            ap_ff, nxt_ap;       // auto precharge pending
	logic            rw_cmd;               // read or write to anyone

	assign rw_cmd = go && (cmd.code == CMD_READ || cmd.code == CMD_WRITE);

	// next state
	always_comb begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff;
		nxt_ap  = ap_ff;
		unique case (st_ff)
			BK_IDLE: begin
				if (go && mine && cmd.code == CMD_ACTIVE)
					nxt_st = BK_ACT;
			end
			BK_ACT: begin
				if (go && mine && cmd.code == CMD_READ) begin
					nxt_st  = BK_RD;
					nxt_cnt = burst_len;
					nxt_ap  = cmd.addr[AP_POS];
				end else if (go && mine && cmd.code == CMD_WRITE) begin
					nxt_st  = BK_WR;
					nxt_cnt = single_wr ? 4'h1 : burst_len;
					nxt_ap  = cmd.addr[AP_POS];
				end else if (go && mine && cmd.code == CMD_PRE) begin
					nxt_st  = BK_PRE;
					nxt_cnt = 4'(RP_CYC);
				end
			end
			BK_RD: begin
				// other-bank burst cuts us; with auto precharge, precharge starts now
				if (rw_cmd && !mine) begin
					nxt_st  = ap_ff ? BK_PRE : BK_ACT;
					nxt_cnt = 4'(RP_CYC);
				end else if (go && mine && cmd.code == CMD_TERM) begin
					nxt_st = BK_ACT;
				end else if (cnt_ff <= 4'h1) begin
					nxt_st  = ap_ff ? BK_PRE : BK_ACT;
					nxt_cnt = 4'(RP_CYC);
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			BK_WR: begin
				// last word was the one before the interrupting command
				if (rw_cmd && !mine) begin
					nxt_st  = ap_ff ? BK_WREC : BK_ACT;
					nxt_cnt = 4'(WR_CYC);
				end else if (go && mine && cmd.code == CMD_TERM) begin
					nxt_st = BK_ACT;
				end else if (cnt_ff <= 4'h1) begin
					nxt_st  = ap_ff ? BK_WREC : BK_ACT;
					nxt_cnt = 4'(WR_CYC);
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			BK_WREC: begin
				// recovery before the automatic precharge
				if (cnt_ff <= 4'h1) begin
					nxt_st  = BK_PRE;
					nxt_cnt = 4'(RP_CYC);
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			BK_PRE: begin
				if (cnt_ff <= 4'h1) begin
					nxt_st = BK_IDLE;
					nxt_ap = 1'b0;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
		endcase
		// precharge-all from any state except idle
		if (go && cmd.code == CMD_PRE && cmd.addr[AP_POS]
		    && st_ff != BK_IDLE) begin
			nxt_st  = BK_PRE;
			nxt_cnt = 4'(RP_CYC);
		end
	end

	// register
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_ff  <= BK_IDLE;
			cnt_ff <= 4'h0;
			ap_ff  <= 1'b0;
		end else begin
			st_ff  <= nxt_st;
			cnt_ff <= nxt_cnt;
			ap_ff  <= nxt_ap;
		end
	end

	assign bursting = (st_ff == BK_RD) || (st_ff == BK_WR);
	assign is_idle  = (st_ff == BK_IDLE);

	// ****************************************
	// checks
	// ****************************************
	a_ap_precharge: assert property (@(posedge mclk) disable iff (srst)
		(st_ff == BK_RD && ap_ff && rw_cmd && !mine)
		|=> st_ff == BK_PRE)
		else $error("auto precharge read not precharging");
	a_wr_recovery: assert property (@(posedge mclk) disable iff (srst)
		(st_ff == BK_WR && ap_ff && rw_cmd && !mine)
		|=> st_ff == BK_WREC)
		else $error("write recovery not started");
	a_plain_cut: assert property (@(posedge mclk) disable iff (srst)
		(st_ff == BK_RD && !ap_ff && rw_cmd && !mine)
		|=> st_ff == BK_ACT)
		else $error("plain read not returned to active");
	c_cut_read: cover property (@(posedge mclk)
		st_ff == BK_RD && rw_cmd && !mine);

endmodule // sdbpim_bank

// ==== core/sdbpim_mode.sv ====
// mode register: loaded by the load command, held until reloaded
// assumes decoded command and an all-banks-idle flag from the top
`timescale 1ns/1ps
module sdbpim_mode (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       srst,
	// load request
	input  wire logic                       go,
	input  wire sdbpim_pkg::sdbpim_cmd_type cmd,
	input  wire logic                       all_idle,
	// fields
	output logic [3:0]                      burst_len,
	output logic                            burst_seq,
	output logic [1:0]                      read_lat,
	output logic                            single_wr,
	output logic [12:0]                     mode_q
);
	import sdbpim_pkg::*;

	// ****************************************
	// operating_mode_config
	// ****************************************
	logic [12:0] mode_ff, nxt_mode;   // stored mode word
	logic        load;                // qualified load

	// only mode-select bank code with all banks idle is taken
	assign load = go && cmd.code == CMD_LOAD && cmd.bank == 2'h0
		&& all_idle;

	always_comb begin
		nxt_mode = mode_ff;
		if (load)
			nxt_mode = {3'h0, cmd.addr[9:0]};
	end

	// no reset pin on the part; srst models power loss
	always_ff @(posedge mclk) begin
		if (srst)
			mode_ff <= MODE_RESET;
		else
			mode_ff <= nxt_mode;
	end

	// decode fields
	always_comb begin
		unique case (mode_ff[BL_LSB +: 3])
			3'h0:    burst_len = 4'h1;
			3'h1:    burst_len = 4'h2;
			3'h2:    burst_len = 4'h4;
			3'h3:    burst_len = 4'h8;
			default: burst_len = 4'hF; // continuous: fifteen words unless cut
		endcase
	end
	assign burst_seq = !mode_ff[BTYPE_POS];
	// only two or three are legal latencies
	assign read_lat  = (mode_ff[LAT_LSB +: 3] == 3'h3) ? 2'h3 : 2'h2;
	assign single_wr = mode_ff[WBM_POS];
	assign mode_q    = mode_ff;

	a_mode_hold: assert property (@(posedge mclk) disable iff (srst)
		!load |=> $stable(mode_ff))
		else $error("mode changed without load");
	c_load: cover property (@(posedge mclk) load);

endmodule // sdbpim_mode

// ==== testbench/sdbpim_ctrl_model.sv ====
// controller model: drives the command pins of the sdram core
// assumes one clock; pins change 1 ns after each rising edge
`timescale 1ns/1ps
module sdbpim_ctrl_model
	import sdbpim_pkg::*;
#(
	parameter int POWERUP_CYC   = 20000, // power-up wait, 100 us at 5 ns
	parameter int REFRESH_CYC   = 14,    // refresh cycle time, plain default
	parameter int MODE_LOAD_CYC = 2,     // mode load time, plain default
	parameter int SREXIT_CYC    = 24     // self refresh exit, plain default
) (
	// clock
	input  wire logic        mclk,
	// command pins
	output logic             cs_n,
	output logic             ras_n,
	output logic             cas_n,
	output logic             we_n,
	output logic             cke,
	output logic [1:0]       bank,
	output logic [12:0]      addr
);
	// ****************************************
	// pin drive
	// ****************************************
	// idle pins at time zero: nop, clock enable high
	initial begin
		{cs_n, ras_n, cas_n, we_n} = CMD_NOP;
		cke  = 1'b1;
		bank = 2'h0;
		addr = 13'h0000;
	end

	// one command per edge; everything held until the next edge
	task automatic issue(input logic [3:0] code, input logic [1:0] bk,
		input logic [12:0] ad, input logic k);
		@(posedge mclk);
		#1;
		{cs_n, ras_n, cas_n, we_n} = code;
		bank = bk;
		addr = ad;
		cke  = k;
	endtask

	// nops with address inverted each cycle, so stale values never match
	task automatic nops(input int n);
		for (int i = 0; i < n; i++) begin
			issue(CMD_NOP, ~bank, ~addr, cke);
		end
	endtask

	// ****************************************
	// sequences
	// ****************************************
	// power-up: wait, precharge all, two refreshes, mode load
	task automatic init(input logic [12:0] mode);
		nops(POWERUP_CYC);
		issue(CMD_PRE, 2'h0, 13'h0400, 1'b1);
		nops(RP_CYC + 1);
		repeat (2) begin
			issue(CMD_REFRESH, 2'h0, 13'h0000, 1'b1);
			nops(REFRESH_CYC);
		end
		issue(CMD_LOAD, 2'h0, mode, 1'b1);
		nops(MODE_LOAD_CYC);
	endtask

	// after self refresh only nops; always more than two of them
	task automatic sr_exit();
		nops(SREXIT_CYC);
	endtask
endmodule // sdbpim_ctrl_model

// ==== testbench/sdbpim_top_tb.sv ====
// testbench for the sdram command core: commands through the model
// assumes 5 ns clock, two sync flops on every command pin
`timescale 1ns/1ps
module sdbpim_top_tb;
	import sdbpim_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic        mclk;        // 200 MHz clock
	logic        srst;        // sync reset
	logic        cs_n;        // command pins from the model
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic        cke;
	logic [1:0]  bank;
	logic [12:0] addr;
	logic [4:0]  power_state; // status from the core
	logic        all_idle;
	logic        read_valid;
	logic        write_taken;
	logic [12:0] mode_word;
	int          failures;    // mismatch count
	int          comparisons; // compare count
	logic [7:0]  rv;          // captured read pulses
	logic [7:0]  wt;          // captured write pulses
	logic [12:0] ap;          // auto precharge address

	sdbpim_top sdbpim_top_i (.mclk(mclk), .srst(srst), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
		.bank(bank), .addr(addr), .power_state(power_state),
		.all_idle(all_idle), .read_valid(read_valid),
		.write_taken(write_taken), .mode_word(mode_word));
	sdbpim_ctrl_model sdbpim_ctrl_model_i (.mclk(mclk), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
		.bank(bank), .addr(addr));

	// clock, half period 2.5 ns
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [3:0] c, input logic [1:0] b,
		input logic [12:0] a);
		sdbpim_ctrl_model_i.issue(c, b, a, 1'b1);
	endtask
	task automatic nop(input int n);
		sdbpim_ctrl_model_i.nops(n);
	endtask
	// sample just after the edge, once updates have landed
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// eight edges of pulses; bit i is edge i+1 after the last nop
	task automatic cap();
		for (int i = 0; i < 8; i++) begin
			step(1);
			rv[i] = read_valid;
			wt[i] = write_taken;
		end
	endtask
	// clock enable command, state looked at four edges later
	task automatic pwr(input logic [3:0] c, input logic k,
		input logic [4:0] exp);
		sdbpim_ctrl_model_i.issue(c, 2'h0, 13'h0000, k);
		nop(1);
		step(3);
		chk({8'h00, power_state}, {8'h00, exp});
	endtask
	task automatic conclude();
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// hang guard: power-up wait plus a few thousand edges
	initial begin
		repeat (26000) @(posedge mclk);
		failures++;
		conclude();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		failures = 0;
		comparisons = 0;
		srst = 1'b1;
		repeat (6) @(posedge mclk);
		#1 srst = 1'b0;
		chk({8'h00, power_state}, 13'h0001);
		chk({12'h000, all_idle}, 13'h0001);
		chk(mode_word, MODE_RESET);
		// init, then upper address bits must be dropped
		sdbpim_ctrl_model_i.init(13'h1E32);
		step(2);
		chk(mode_word, 13'h0232);
		// load with bank select set is not the mode register
		sdbpim_ctrl_model_i.issue(CMD_LOAD, 2'h1, 13'h0022, 1'b1);
		nop(1);
		step(3);
		chk(mode_word, 13'h0232);
		// latency three: pulse four edges after the nop
		cmd(CMD_ACTIVE, 2'h0, 13'h0000);
		nop(3);
		cmd(CMD_READ, 2'h0, 13'h0000);
		nop(1);
		cap();
		chk({5'h00, rv}, 13'h0008);
		// load refused while a bank is open
		cmd(CMD_LOAD, 2'h0, 13'h0022);
		nop(1);
		step(3);
		chk(mode_word, 13'h0232);
		cmd(CMD_PRE, 2'h0, 13'h0400);
		nop(8);
		cmd(CMD_LOAD, 2'h0, 13'h0022);
		nop(1);
		step(3);
		chk(mode_word, 13'h0022);
		// every pair of read/write, with and without auto precharge
		for (int i = 0; i < 8; i++) begin
			ap = {2'b00, i[2], 10'h000};
			cmd(CMD_ACTIVE, 2'h0, 13'h0000);
			cmd(CMD_ACTIVE, 2'h1, 13'h0000);
			nop(3);
			cmd(i[0] ? CMD_WRITE : CMD_READ, 2'h0, ap);
			cmd(i[1] ? CMD_WRITE : CMD_READ, 2'h1, ap);
			nop(1);
			cap();
			chk({5'h00, rv}, {10'h000, ~i[1], ~i[0], 1'b0});
			chk({5'h00, wt}, {11'h000, i[1], i[0]});
			step(10);
			// open banks stay open; auto precharge closes both
			chk({12'h000, all_idle}, {12'h000, i[2]});
			if (!i[2]) begin
				cmd(CMD_PRE, 2'h0, 13'h0400);
				nop(8);
			end
		end
		// single-location writes: auto precharge closes the bank early
		cmd(CMD_LOAD, 2'h0, 13'h0222);
		nop(3);
		chk(mode_word, 13'h0222);
		cmd(CMD_ACTIVE, 2'h0, 13'h0000);
		nop(3);
		cmd(CMD_WRITE, 2'h0, 13'h0400);
		step(12);
		chk({12'h000, all_idle}, 13'h0001);
		// clock enable machine
		pwr(CMD_TERM, 1'b1, 5'h01);
		pwr(CMD_NOP, 1'b0, 5'h02);
		step(5);
		chk({8'h00, power_state}, 13'h0002);
		pwr(CMD_NOP, 1'b1, 5'h01);
		chk({12'h000, all_idle}, 13'h0001);
		pwr(CMD_REFRESH, 1'b0, 5'h04);
		step(5);
		chk({8'h00, power_state}, 13'h0004);
		pwr(CMD_NOP, 1'b1, 5'h01);
		sdbpim_ctrl_model_i.sr_exit();
		// suspend in mid burst, then the next read is taken
		cmd(CMD_ACTIVE, 2'h0, 13'h0000);
		nop(3);
		cmd(CMD_READ, 2'h0, 13'h0000);
		pwr(CMD_NOP, 1'b0, 5'h08);
		pwr(CMD_NOP, 1'b1, 5'h01);
		cmd(CMD_READ, 2'h0, 13'h0000);
		nop(1);
		cap();
		chk({5'h00, rv}, 13'h0004);
		cmd(CMD_PRE, 2'h0, 13'h0400);
		nop(8);
		pwr(CMD_TERM, 1'b0, 5'h10);
		conclude();
	end
endmodule // sdbpim_top_tb
